//--- hdl/standby_mode_controller.sv
// Standby mode controller: reset vector, HALT, STOP and wake-up sequencing
// Operation
// - Hardware resets start from vector at 0002H/0003H
// - Break reset starts from vector at 0004H/0005H
// - Break at level two or more uses 0002H
// - Halt request bit write enters HALT
// - Enabled or watchdog request ends HALT, clears bit
// - Stop needs 5n then An unlock writes
// - Entering STOP relocks the stop unlock
// - STOP halts both oscillators, CPU, peripherals
// - Only enabled wake inputs end STOP
// - Slow wake restarts fast oscillator only if running
// - Slow wake releases after 128 RC ticks
// - Crystal switch after start time plus 8192 pulses
// - Fast wake releases after start plus 4096 pulses
// - Fast wake resumes slow clock after 128 ticks
// - Non-maskable wake vectors unless level is three
// - Maskable wake vectors only if enabled, level low
// - Level field encodes none, maskable, NMI, emulator
// - Accepted interrupt clears the master enable
`timescale 1ns/1ps
`default_nettype none

module standby_mode_controller #(
	parameter int SRC_N          = 8,
	parameter int TMR_W          = 24,
	parameter int SLOW_START_CYC = standby_pkg::SLOW_START_CYC,
	parameter int FAST_START_CYC = standby_pkg::FAST_START_CYC
) (
	input  wire logic             i_core_clk,
	input  wire logic             i_srst,
	input  wire logic             i_hw_reset_event,
	input  wire logic             i_break_exec,
	input  wire logic             i_sysrst_release,
	input  wire logic [1:0]       i_interrupt_level_field,
	input  wire logic             i_master_irq_enable,
	input  wire logic             i_halt_request_wr,
	input  wire logic             i_stop_request_wr,
	input  wire logic             i_stop_unlock_wr,
	input  wire logic [7:0]       i_stop_unlock_data,
	input  wire logic             i_watchdog_irq_req,
	input  wire logic [SRC_N-1:0] i_source_request_flag,
	input  wire logic [SRC_N-1:0] i_source_enable_flag,
	input  wire logic [3:0]       i_wake_request_flag,
	input  wire logic [3:0]       i_wake_enable_flag,
	input  wire logic             i_cpu_on_fast_clk,
	input  wire logic             i_fast_osc_running,
	input  wire logic             i_rc_clk,
	input  wire logic             i_slow_xtal_clk,
	input  wire logic             i_fast_osc_clk,
	output logic [15:0]           o_vec_lo_addr,
	output logic [15:0]           o_vec_hi_addr,
	output logic                  o_halt_request_bit,
	output logic                  o_stop_request_bit,
	output logic                  o_stop_unlocked,
	output logic                  o_cpu_run,
	output logic                  o_resume,
	output logic                  o_vector_entry,
	output logic                  o_mie_clear,
	output logic                  o_slow_osc_en,
	output logic                  o_fast_osc_en,
	output logic                  o_slow_periph_clk_en,
	output logic                  o_fast_periph_clk_en,
	output logic                  o_slow_clk_on_crystal,
	output logic                  o_slow_clock_switch_irq
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	standby_pkg::mode_t   state_r;
	standby_pkg::mode_t   state_nxt;
	standby_pkg::unlock_t unlock_r;
	standby_pkg::unlock_t unlock_nxt;

	logic [2:0]       sync1_r;
	logic [2:0]       sync2_r;
	logic [2:0]       sync3_r;
	logic             brk_pending_r;
	logic             brk_alt_r;
	logic             fast_mode_r;
	logic             fast_was_on_r;
	logic             rc_busy_r;
	logic [7:0]       rc_cnt_r;
	logic             slow_busy_r;
	logic [TMR_W-1:0] slow_tmr_r;
	logic [13:0]      slow_pcnt_r;
	logic             fast_busy_r;
	logic [TMR_W-1:0] fast_tmr_r;
	logic [12:0]      fast_pcnt_r;

	////////////////////////////////////////////////////////////////////////////
	// Decoding

	// Oscillator pins are asynchronous; edges are taken past the second stage
	wire [2:0] osc_edge  = sync2_r & ~sync3_r;
	wire       rc_edge   = osc_edge[0];
	wire       slow_edge = osc_edge[1];
	wire       fast_edge = osc_edge[2];

	wire in_run  = (state_r == standby_pkg::ST_RUN);
	wire in_halt = (state_r == standby_pkg::ST_HALT);
	wire in_stop = (state_r == standby_pkg::ST_STOP);
	wire in_wake = (state_r == standby_pkg::ST_WAKE);

	wire lvl_high  = (i_interrupt_level_field >= standby_pkg::LVL_NMI);
	wire lvl_emu   = (i_interrupt_level_field == standby_pkg::LVL_EMU);
	wire lvl_low   = (i_interrupt_level_field == standby_pkg::LVL_NONE) ||
		(i_interrupt_level_field == standby_pkg::LVL_MASKABLE);

	wire nmi_wake  = i_watchdog_irq_req;
	wire mask_wake = |(i_source_request_flag & i_source_enable_flag);
	wire mask_vec  = i_master_irq_enable & lvl_low;
	wire halt_wake = in_halt & (nmi_wake | mask_wake);
	wire halt_vec  = (nmi_wake & ~lvl_emu) | (mask_wake & mask_vec);
	wire stop_wake = in_stop & (|(i_wake_request_flag & i_wake_enable_flag));

	wire first_code  = i_stop_unlock_wr &
		(i_stop_unlock_data[7:4] == standby_pkg::UNLOCK_FIRST_NIB);
	wire second_code = (i_stop_unlock_data[7:4] == standby_pkg::UNLOCK_SECOND_NIB);
	wire stop_enter  = in_run & i_stop_request_wr & (unlock_r == standby_pkg::LK_OPEN);
	wire halt_enter  = in_run & i_halt_request_wr & ~stop_enter;

	wire rc_done   = rc_busy_r & (rc_cnt_r == standby_pkg::RC_WAKE_TICKS);
	wire slow_tdone = (slow_tmr_r == TMR_W'(SLOW_START_CYC));
	wire fast_tdone = (fast_tmr_r == TMR_W'(FAST_START_CYC));
	wire slow_done = slow_busy_r & slow_tdone &
		(slow_pcnt_r == standby_pkg::SLOW_STABLE_PULSES);
	wire fast_done = fast_busy_r & fast_tdone &
		(fast_pcnt_r == standby_pkg::FAST_STABLE_PULSES);
	wire release_w = in_wake & (fast_mode_r ? fast_done : rc_done);
	wire accept    = (halt_wake & halt_vec) | (release_w & mask_vec);

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			standby_pkg::ST_RUN: begin
				if (stop_enter)
					state_nxt = standby_pkg::ST_STOP;
				else if (halt_enter)
					state_nxt = standby_pkg::ST_HALT;
			end
			standby_pkg::ST_HALT: begin
				if (halt_wake)
					state_nxt = standby_pkg::ST_RUN;
			end
			standby_pkg::ST_STOP: begin
				if (stop_wake)
					state_nxt = standby_pkg::ST_WAKE;
			end
			standby_pkg::ST_WAKE: begin
				if (release_w)
					state_nxt = standby_pkg::ST_RUN;
			end
		endcase
	end

	always_comb begin
		unlock_nxt = unlock_r;
		unique case (unlock_r)
			standby_pkg::LK_LOCKED: begin
				if (first_code)
					unlock_nxt = standby_pkg::LK_HALF;
			end
			standby_pkg::LK_HALF: begin
				// Any other second write falls back to locked
				if (i_stop_unlock_wr)
					unlock_nxt = second_code ? standby_pkg::LK_OPEN : standby_pkg::LK_LOCKED;
			end
			standby_pkg::LK_OPEN: begin
				if (stop_enter)
					unlock_nxt = standby_pkg::LK_LOCKED;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge i_core_clk) begin
		sync1_r <= {i_fast_osc_clk, i_slow_xtal_clk, i_rc_clk};
		sync2_r <= sync1_r;
		sync3_r <= sync2_r;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			state_r  <= standby_pkg::ST_RUN;
			unlock_r <= standby_pkg::LK_LOCKED;
		end else begin
			state_r  <= state_nxt;
			unlock_r <= unlock_nxt;
		end
	end

	// Reset vector selection; a break in the same cycle as a hardware reset wins
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			brk_pending_r <= 1'b0;
			brk_alt_r     <= 1'b0;
			o_vec_lo_addr <= standby_pkg::VEC_NORMAL_LO;
			o_vec_hi_addr <= standby_pkg::VEC_NORMAL_HI;
		end else begin
			if (i_break_exec) begin
				brk_pending_r <= 1'b1;
				brk_alt_r     <= lvl_high;
			end else if (i_hw_reset_event) begin
				brk_pending_r <= 1'b0;
			end
			if (i_sysrst_release) begin
				// Cause is used once, so a later release is not taken as a break
				if (!i_break_exec)
					brk_pending_r <= 1'b0;
				if (brk_pending_r && !brk_alt_r) begin
					o_vec_lo_addr <= standby_pkg::VEC_BREAK_LO;
					o_vec_hi_addr <= standby_pkg::VEC_BREAK_HI;
				end else begin
					o_vec_lo_addr <= standby_pkg::VEC_NORMAL_LO;
					o_vec_hi_addr <= standby_pkg::VEC_NORMAL_HI;
				end
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_halt_request_bit <= 1'b0;
			o_stop_request_bit <= 1'b0;
			o_stop_unlocked    <= 1'b0;
			o_cpu_run          <= 1'b1;
			o_resume           <= 1'b0;
			o_vector_entry     <= 1'b0;
			o_mie_clear        <= 1'b0;
			fast_mode_r        <= 1'b0;
			fast_was_on_r      <= 1'b0;
		end else begin
			if (halt_enter)
				o_halt_request_bit <= 1'b1;
			else if (halt_wake)
				o_halt_request_bit <= 1'b0;
			if (stop_enter)
				o_stop_request_bit <= 1'b1;
			else if (stop_wake)
				o_stop_request_bit <= 1'b0;
			if (stop_enter) begin
				fast_mode_r   <= i_cpu_on_fast_clk;
				fast_was_on_r <= i_fast_osc_running;
			end
			o_stop_unlocked <= (unlock_nxt == standby_pkg::LK_OPEN);
			o_cpu_run       <= (state_nxt == standby_pkg::ST_RUN);
			o_resume        <= halt_wake | release_w;
			o_vector_entry  <= accept;
			o_mie_clear     <= accept;
		end
	end

	// Wake counters keep running after release until their own event is done
	always_ff @(posedge i_core_clk) begin
		if (i_srst || stop_enter) begin
			rc_busy_r   <= 1'b0;
			rc_cnt_r    <= 8'h00;
			slow_busy_r <= 1'b0;
			slow_tmr_r  <= '0;
			slow_pcnt_r <= 14'h0000;
			fast_busy_r <= 1'b0;
			fast_tmr_r  <= '0;
			fast_pcnt_r <= 13'h0000;
		end else if (stop_wake) begin
			rc_busy_r   <= 1'b1;
			slow_busy_r <= 1'b1;
			fast_busy_r <= fast_mode_r;
		end else begin
			if (rc_done)
				rc_busy_r <= 1'b0;
			else if (rc_busy_r && rc_edge)
				rc_cnt_r <= rc_cnt_r + 8'h01;
			if (slow_done)
				slow_busy_r <= 1'b0;
			else if (slow_busy_r && !slow_tdone)
				slow_tmr_r <= slow_tmr_r + TMR_W'(1);
			else if (slow_busy_r && slow_edge)
				slow_pcnt_r <= slow_pcnt_r + 14'h0001;
			if (fast_done)
				fast_busy_r <= 1'b0;
			else if (fast_busy_r && !fast_tdone)
				fast_tmr_r <= fast_tmr_r + TMR_W'(1);
			else if (fast_busy_r && fast_edge)
				fast_pcnt_r <= fast_pcnt_r + 13'h0001;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_slow_osc_en           <= 1'b1;
			o_fast_osc_en           <= 1'b1;
			o_slow_periph_clk_en    <= 1'b1;
			o_fast_periph_clk_en    <= 1'b1;
			o_slow_clk_on_crystal   <= 1'b0;
			o_slow_clock_switch_irq <= 1'b0;
		end else begin
			o_slow_clock_switch_irq <= slow_done;
			if (stop_enter) begin
				o_slow_osc_en         <= 1'b0;
				o_fast_osc_en         <= 1'b0;
				o_slow_periph_clk_en  <= 1'b0;
				o_fast_periph_clk_en  <= 1'b0;
				o_slow_clk_on_crystal <= 1'b0;
			end else begin
				if (stop_wake) begin
					o_slow_osc_en <= 1'b1;
					o_fast_osc_en <= fast_mode_r | fast_was_on_r;
				end
				if (rc_done) begin
					o_slow_periph_clk_en <= 1'b1;
					if (!fast_mode_r && fast_was_on_r)
						o_fast_periph_clk_en <= 1'b1;
				end
				if (fast_done)
					o_fast_periph_clk_en <= 1'b1;
				if (slow_done)
					o_slow_clk_on_crystal <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_srst);

	sequence stop_entry_s;
		in_run && i_stop_request_wr && (unlock_r == standby_pkg::LK_OPEN);
	endsequence

	sequence stop_asleep_s;
		##1 in_stop && o_stop_request_bit && !o_cpu_run;
	endsequence

	stop_relock_a: assert property (stop_entry_s |-> stop_asleep_s ##0
		(unlock_r == standby_pkg::LK_LOCKED))
		else $error("stop entry did not relock or stop");
	stop_osc_off_a: assert property (in_stop |-> !o_slow_osc_en && !o_fast_osc_en &&
		!o_slow_periph_clk_en && !o_fast_periph_clk_en)
		else $error("clock left running in stop");
	stop_locked_a: assert property (in_run && i_stop_request_wr &&
		(unlock_r != standby_pkg::LK_OPEN) |=> !in_stop)
		else $error("stop entered without unlock");
	halt_entry_a: assert property (in_run && i_halt_request_wr && !i_stop_request_wr
		|=> in_halt && o_halt_request_bit && !o_cpu_run)
		else $error("halt not entered");
	halt_wake_a: assert property (in_halt && (i_watchdog_irq_req || mask_wake)
		|=> in_run && !o_halt_request_bit && o_resume && o_cpu_run)
		else $error("halt not released");
	stop_wake_a: assert property (stop_wake |=> in_wake && !o_stop_request_bit &&
		o_slow_osc_en && !o_cpu_run)
		else $error("stop wake not taken");
	slow_fast_osc_a: assert property (in_wake && !fast_mode_r && !fast_was_on_r
		|-> !o_fast_osc_en)
		else $error("fast oscillator restarted");
	slow_release_a: assert property (in_wake && !fast_mode_r && rc_done
		|=> in_run && o_slow_periph_clk_en && o_resume)
		else $error("slow wake release missed");
	fast_release_a: assert property (in_wake && fast_mode_r && fast_done
		|=> in_run && o_fast_periph_clk_en && o_resume)
		else $error("fast wake release missed");
	fast_slow_clk_a: assert property (fast_mode_r && rc_done
		|=> o_slow_periph_clk_en && !rc_busy_r)
		else $error("slow clock not resumed");
	xtal_switch_a: assert property (slow_done |=> o_slow_clk_on_crystal &&
		o_slow_clock_switch_irq ##1 !o_slow_clock_switch_irq)
		else $error("crystal switch wrong");
	nmi_level3_a: assert property (in_halt && i_watchdog_irq_req && lvl_emu && !mask_wake
		|=> o_resume && !o_vector_entry)
		else $error("vectored at emulator level");
	mask_novec_a: assert property (in_halt && mask_wake && !i_watchdog_irq_req &&
		(!i_master_irq_enable || lvl_high) |=> o_resume && !o_vector_entry)
		else $error("maskable vectored wrongly");
	mie_clear_a: assert property (o_vector_entry == o_mie_clear)
		else $error("master enable clear mismatch");
	brk_vec_a: assert property (i_sysrst_release && brk_pending_r && !brk_alt_r
		|=> o_vec_lo_addr == 16'h0004 && o_vec_hi_addr == 16'h0005)
		else $error("break vector wrong");
	hw_vec_a: assert property (i_sysrst_release && (!brk_pending_r || brk_alt_r)
		|=> o_vec_lo_addr == 16'h0002 && o_vec_hi_addr == 16'h0003)
		else $error("normal vector wrong");

endmodule : standby_mode_controller

`default_nettype wire

//--- hdl/standby_pkg.sv
// Constants, timing counts and state encodings of the standby mode controller
package standby_pkg;

	// Start address locations in program memory
	localparam logic [15:0] VEC_NORMAL_LO = 16'h0002;
	localparam logic [15:0] VEC_NORMAL_HI = 16'h0003;
	localparam logic [15:0] VEC_BREAK_LO  = 16'h0004;
	localparam logic [15:0] VEC_BREAK_HI  = 16'h0005;

	// Interrupt level field encoding
	localparam logic [1:0] LVL_NONE     = 2'h0;
	localparam logic [1:0] LVL_MASKABLE = 2'h1;
	localparam logic [1:0] LVL_NMI      = 2'h2;
	localparam logic [1:0] LVL_EMU      = 2'h3;

	// Stop unlock codes, upper nibble only
	localparam logic [3:0] UNLOCK_FIRST_NIB  = 4'h5;
	localparam logic [3:0] UNLOCK_SECOND_NIB = 4'ha;

	// Wake-up pulse counts
	localparam logic [7:0]  RC_WAKE_TICKS      = 8'h80;
	localparam logic [13:0] SLOW_STABLE_PULSES = 14'h2000;
	localparam logic [12:0] FAST_STABLE_PULSES = 13'h1000;

	// Core clock and oscillator start times
	localparam int CLK_PERIOD_NS      = 40;
	localparam int SLOW_START_TIME_US = 1000;
	localparam int FAST_START_TIME_US = 100;
	localparam int SLOW_START_CYC     = (SLOW_START_TIME_US * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int FAST_START_CYC     = (FAST_START_TIME_US * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;

	typedef enum logic [3:0] {
		ST_RUN  = 4'h1,
		ST_HALT = 4'h2,
		ST_STOP = 4'h4,
		ST_WAKE = 4'h8
	} mode_t;

	typedef enum logic [2:0] {
		LK_LOCKED = 3'h1,
		LK_HALF   = 3'h2,
		LK_OPEN   = 3'h4
	} unlock_t;

endpackage : standby_pkg

//--- tb/osc_model.sv
// Oscillator partner: RC, slow crystal and fast oscillator sources
`timescale 1ns/1ps
`default_nettype none

module osc_model #(
	parameter int RC_HALF_NS   = 50,
	parameter int SLOW_HALF_NS = 55,
	parameter int FAST_HALF_NS = 45
) (
	input  wire logic i_slow_osc_en,
	input  wire logic i_fast_osc_en,
	output var  logic o_rc_clk,
	output var  logic o_slow_xtal_clk,
	output var  logic o_fast_osc_clk
);
	initial begin
		o_rc_clk        = 1'b0;
		o_slow_xtal_clk = 1'b0;
		o_fast_osc_clk  = 1'b0;
	end
	// Sources stand still low while disabled, no stray edges to count
	always begin
		#(RC_HALF_NS);
		o_rc_clk = i_slow_osc_en ? ~o_rc_clk : 1'b0;
	end
	always begin
		#(SLOW_HALF_NS);
		o_slow_xtal_clk = i_slow_osc_en ? ~o_slow_xtal_clk : 1'b0;
	end
	always begin
		#(FAST_HALF_NS);
		o_fast_osc_clk = i_fast_osc_en ? ~o_fast_osc_clk : 1'b0;
	end
endmodule : osc_model

`default_nettype wire

//--- tb/standby_mode_controller_tb_top.sv
// Testbench of the standby mode controller
`timescale 1ns/1ps
`default_nettype none

module standby_mode_controller_tb_top;
	logic i_core_clk, i_srst, i_hw_reset_event, i_break_exec, i_sysrst_release;
	logic i_master_irq_enable, i_halt_request_wr, i_stop_request_wr, i_stop_unlock_wr;
	logic i_watchdog_irq_req, i_cpu_on_fast_clk, i_fast_osc_running;
	logic [1:0]  i_interrupt_level_field;
	logic [7:0]  i_stop_unlock_data, i_source_request_flag, i_source_enable_flag;
	logic [3:0]  i_wake_request_flag, i_wake_enable_flag;
	wire  logic  rc_clk, slow_clk, fast_clk;
	logic [15:0] o_vec_lo_addr, o_vec_hi_addr;
	logic o_halt_request_bit, o_stop_request_bit, o_stop_unlocked, o_cpu_run, o_resume;
	logic o_vector_entry, o_mie_clear, o_slow_osc_en, o_fast_osc_en;
	logic o_slow_periph_clk_en, o_fast_periph_clk_en, o_slow_clk_on_crystal;
	logic o_slow_clock_switch_irq;
	int   errors, comparisons, cycles;

	standby_mode_controller #(.SRC_N(8), .TMR_W(24), .SLOW_START_CYC(4), .FAST_START_CYC(4))
	u_dut (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_hw_reset_event(i_hw_reset_event),
		.i_break_exec(i_break_exec), .i_sysrst_release(i_sysrst_release),
		.i_interrupt_level_field(i_interrupt_level_field),
		.i_master_irq_enable(i_master_irq_enable), .i_halt_request_wr(i_halt_request_wr),
		.i_stop_request_wr(i_stop_request_wr), .i_stop_unlock_wr(i_stop_unlock_wr),
		.i_stop_unlock_data(i_stop_unlock_data), .i_watchdog_irq_req(i_watchdog_irq_req),
		.i_source_request_flag(i_source_request_flag),
		.i_source_enable_flag(i_source_enable_flag),
		.i_wake_request_flag(i_wake_request_flag), .i_wake_enable_flag(i_wake_enable_flag),
		.i_cpu_on_fast_clk(i_cpu_on_fast_clk), .i_fast_osc_running(i_fast_osc_running),
		.i_rc_clk(rc_clk), .i_slow_xtal_clk(slow_clk), .i_fast_osc_clk(fast_clk),
		.o_vec_lo_addr(o_vec_lo_addr), .o_vec_hi_addr(o_vec_hi_addr),
		.o_halt_request_bit(o_halt_request_bit), .o_stop_request_bit(o_stop_request_bit),
		.o_stop_unlocked(o_stop_unlocked), .o_cpu_run(o_cpu_run), .o_resume(o_resume),
		.o_vector_entry(o_vector_entry), .o_mie_clear(o_mie_clear),
		.o_slow_osc_en(o_slow_osc_en), .o_fast_osc_en(o_fast_osc_en),
		.o_slow_periph_clk_en(o_slow_periph_clk_en),
		.o_fast_periph_clk_en(o_fast_periph_clk_en),
		.o_slow_clk_on_crystal(o_slow_clk_on_crystal),
		.o_slow_clock_switch_irq(o_slow_clock_switch_irq));

	osc_model u_osc (.i_slow_osc_en(o_slow_osc_en), .i_fast_osc_en(o_fast_osc_en),
		.o_rc_clk(rc_clk), .o_slow_xtal_clk(slow_clk), .o_fast_osc_clk(fast_clk));

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		i_core_clk = 1'b0;
		forever #20 i_core_clk = ~i_core_clk;
	end

	// Ceiling well above the three stop wakes, each near 23000 cycles
	always @(posedge i_core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			errors = errors + 1;
			stop_test();
		end
	end

	task automatic stop_test();
		if (errors == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test

	task automatic tick();
		@(posedge i_core_clk);
		#1;
	endtask : tick

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons = comparisons + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic pulse(input int k);
		case (k)
			0: i_sysrst_release = 1'b1;
			1: i_break_exec = 1'b1;
			2: i_hw_reset_event = 1'b1;
			3: i_halt_request_wr = 1'b1;
			4: i_stop_request_wr = 1'b1;
			default: i_stop_unlock_wr = 1'b1;
		endcase
		tick();
		{i_sysrst_release, i_break_exec, i_hw_reset_event} = 3'h0;
		{i_halt_request_wr, i_stop_request_wr, i_stop_unlock_wr} = 3'h0;
		tick();
	endtask : pulse

	function automatic logic pick(input int k);
		case (k)
			0: pick = o_resume;
			1: pick = o_slow_clock_switch_irq;
			default: pick = o_slow_periph_clk_en;
		endcase
	endfunction : pick

	task automatic wait_sig(input int k, input int limit);
		int n;
		n = 0;
		while (pick(k) !== 1'b1 && n < limit) begin
			tick();
			n = n + 1;
		end
		chk(16'(pick(k)), 16'h1);
	endtask : wait_sig

	task automatic unlock(input logic [7:0] d);
		i_stop_unlock_data = d;
		pulse(5);
	endtask : unlock

	task automatic vec_case(input logic [1:0] lvl, input int k, input logic [15:0] lo);
		i_interrupt_level_field = lvl;
		pulse(1);
		if (k != 1) pulse(k);
		pulse(0);
		chk(o_vec_lo_addr, lo);
		chk(o_vec_hi_addr, lo + 16'h1);
	endtask : vec_case

	task automatic halt_case(input logic wd, input logic master_irq_enable, input logic [1:0] lvl,
		input logic exp_vec);
		i_master_irq_enable = master_irq_enable;
		i_interrupt_level_field = lvl;
		pulse(3);
		chk(o_halt_request_bit, 1'b1);
		chk(o_cpu_run, 1'b0);
		i_source_request_flag = wd ? 8'h00 : 8'h10;
		repeat (4) tick();
		chk(o_halt_request_bit, 1'b1);
		i_watchdog_irq_req = wd;
		i_source_enable_flag = wd ? 8'h00 : 8'h10;
		wait_sig(0, 4);
		chk(o_halt_request_bit, 1'b0);
		chk(o_vector_entry, exp_vec);
		chk(o_mie_clear, exp_vec);
		{i_watchdog_irq_req, i_source_request_flag, i_source_enable_flag} = 17'h0;
		tick();
	endtask : halt_case

	task automatic stop_case(input logic fast, input logic run);
		i_cpu_on_fast_clk = fast;
		i_fast_osc_running = fast | run;
		i_master_irq_enable = 1'b1;
		i_interrupt_level_field = 2'h0;
		unlock(8'h5c);
		unlock(8'ha3);
		chk(o_stop_unlocked, 1'b1);
		pulse(4);
		chk(o_stop_request_bit, 1'b1);
		chk(o_stop_unlocked, 1'b0);
		chk({o_slow_osc_en, o_fast_osc_en, o_slow_periph_clk_en, o_fast_periph_clk_en}, 0);
		i_wake_request_flag = 4'h4;
		repeat (4) tick();
		chk(o_stop_request_bit, 1'b1);
		i_wake_enable_flag = 4'h4;
		repeat (3) tick();
		chk(o_slow_osc_en, 1'b1);
		chk(o_fast_osc_en, fast | run);
		if (fast) begin
			wait_sig(2, 1000);
			chk(o_cpu_run, 1'b0);
			wait_sig(0, 12000);
			chk(o_fast_periph_clk_en, 1'b1);
		end else begin
			wait_sig(0, 1000);
			chk(o_slow_periph_clk_en, 1'b1);
			chk(o_fast_periph_clk_en, 16'(run));
		end
		chk(o_vector_entry, 1'b1);
		chk(o_stop_request_bit, 1'b0);
		i_wake_request_flag = 4'h0;
		i_wake_enable_flag = 4'h0;
		wait_sig(1, 30000);
		chk(o_slow_clk_on_crystal, 1'b1);
	endtask : stop_case

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		errors = 0;
		comparisons = 0;
		cycles = 0;
		i_srst = 1'b1;
		{i_hw_reset_event, i_break_exec, i_sysrst_release, i_master_irq_enable} = 4'h0;
		{i_halt_request_wr, i_stop_request_wr, i_stop_unlock_wr, i_watchdog_irq_req} = 4'h0;
		{i_cpu_on_fast_clk, i_fast_osc_running, i_interrupt_level_field} = 4'h0;
		{i_stop_unlock_data, i_source_request_flag, i_source_enable_flag} = 24'h0;
		{i_wake_request_flag, i_wake_enable_flag} = 8'h0;
		repeat (20) tick();
		i_srst = 1'b0;
		tick();
		chk({o_cpu_run, o_halt_request_bit, o_stop_request_bit, o_slow_clk_on_crystal}, 16'h8);
		pulse(0);
		chk(o_vec_lo_addr, 16'h0002);
		vec_case(2'h1, 1, 16'h0004);
		vec_case(2'h2, 1, 16'h0002);
		vec_case(2'h1, 2, 16'h0002);
		halt_case(1'b1, 1'b0, 2'h3, 1'b0);
		halt_case(1'b1, 1'b0, 2'h2, 1'b1);
		halt_case(1'b0, 1'b0, 2'h0, 1'b0);
		halt_case(1'b0, 1'b1, 2'h2, 1'b0);
		halt_case(1'b0, 1'b1, 2'h1, 1'b1);
		halt_case(1'b0, 1'b1, 2'h0, 1'b1);
		pulse(4);
		chk(o_stop_request_bit, 1'b0);
		unlock(8'h51);
		unlock(8'h3a);
		chk(o_stop_unlocked, 1'b0);
		pulse(4);
		chk(o_stop_request_bit, 1'b0);
		stop_case(1'b0, 1'b0);
		stop_case(1'b0, 1'b1);
		stop_case(1'b1, 1'b1);
		stop_test();
	end
endmodule : standby_mode_controller_tb_top

`default_nettype wire
